/* File: dv/tb_top.sv */
// self-checking bench for the fractional baud block
`timescale 1ns/1ns
module tb_top;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [5:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic tx_en_o, rx_en_o, tx_fifo_en_o, rx_fifo_en_o, tx_tick_o, rx_tick_o;
  logic [19:0] tx_gap, rx_gap;
  int fail_count = 0, n_checks = 0, cyc_cnt = 0;
  ufb_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_en_o(tx_en_o), .rx_en_o(rx_en_o), .tx_fifo_en_o(tx_fifo_en_o),
    .rx_fifo_en_o(rx_fifo_en_o), .tx_tick_o(tx_tick_o), .rx_tick_o(rx_tick_o));
  ufb_peer u_ptx (.clk_i(clk_i), .tick_i(tx_tick_o), .gap_o(tx_gap));
  ufb_peer u_prx (.clk_i(clk_i), .tick_i(rx_tick_o), .gap_o(rx_gap));
  always #4 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // the request stays up until ack is seen at an edge
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  task en_chk(input logic [3:0] e);
    repeat (2) @(posedge clk_i);
    chk("enables", {28'h0, e}, {28'h0, tx_fifo_en_o, rx_fifo_en_o, tx_en_o, rx_en_o});
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    for (int a = 3; a <= 10; a++) rdc("reset value", a[5:0], 32'h0000_0000);
    rdc("unmapped", 6'h3F, 32'h0000_0000);
    $display("reset test done");
  endtask
  task t_bringup;
    wr(6'h30, 32'h0000_0001);
    en_chk(4'h8);
    wr(6'h03, 32'h0000_0003);
    en_chk(4'hB);
    wr(6'h30, 32'h0000_0003);
    en_chk(4'hF);
    wr(6'h03, 32'h0000_0001);
    en_chk(4'hE);
    // ones written to the reserved enable bits are dropped and read back as zero
    wr(6'h03, 32'h0000_0002);
    en_chk(4'hD);
    rdc("gate reserved", 6'h03, 32'h0000_0002);
    wr(6'h30, 32'h0000_00FC);
    rdc("fifo reserved", 6'h30, 32'h0000_0000);
    rdc("status", 6'h21, 32'h0000_0002);
    $display("bring-up test done");
  endtask
  task t_div;
    for (int a = 4; a <= 6; a++) wr(a[5:0], 32'h0000_00FF);
    rdc("div low", 6'h04, 32'h0000_00FF);
    rdc("div high", 6'h06, 32'h0000_0007);
    $display("divisor test done");
  endtask
  task t_lookup;
    int ix [4] = '{0, 1, 21, 31};
    logic [47:0] m [4] = '{48'h0, 48'h0, 48'h0B6D_0B6A_0DB6, 48'h0FFF_0FFE_0FFD};
    logic [15:0] rx;
    for (int p = 0; p < 2; p++) begin
      wr(6'h04, 32'h0000_0010 + p);
      for (int k = 0; k < 4; k++) begin
        rx = p ? m[k][15:0] : m[k][31:16];
        wr(6'h20, 32'h0000_0100 | ix[k]);
        rdc("lookup", 6'h20, {rx, m[k][47:32]});
        rdc("tx mask", 6'h07, {24'h0, m[k][39:32]});
        rdc("rx mask", 6'h0A, {24'h0, rx[15:8]});
      end
    end
    // 115200 bit/s: divisor 416 and index 21 give the ready-made masks
    wr(6'h04, 32'h0000_00A0);
    wr(6'h05, 32'h0000_0001);
    wr(6'h06, 32'h0000_0000);
    wr(6'h20, 32'h0000_0115);
    rdc("115200 tx low", 6'h07, 32'h0000_006D);
    rdc("115200 tx high", 6'h08, 32'h0000_000B);
    rdc("115200 rx low", 6'h09, 32'h0000_006A);
    rdc("115200 rx high", 6'h0A, 32'h0000_000B);
    // an index write without the apply bit leaves the masks alone
    wr(6'h20, 32'h0000_0005);
    rdc("no apply", 6'h07, 32'h0000_006D);
    $display("lookup test done");
  endtask
  task t_baud;
    int s;
    logic [31:0] cfg [7] = '{10, 0, 0, 'h6D, 'h0B, 'h6A, 'h0B};
    // divisor 10 with the index 21 masks, even column: a rate near 4.5 Mbit/s
    for (int a = 0; a < 7; a++) wr(6'(a + 4), cfg[a]);
    wr(6'h03, 32'h0000_0003);
    for (int r = 0; r < 2; r++) begin
      s = 0;
      for (int i = 0; i < 17; i++) begin
        do @(posedge clk_i); while ((r ? rx_tick_o : tx_tick_o) !== 1'b1);
        #1;
        if (i > 0) s += r ? rx_gap : tx_gap;
      end
      chk("mask cycle span", r ? 32'd167 : 32'd168, s);
    end
    $display("baud test done");
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc_cnt++;
    // ceiling well above the several hundred cycles the tests need
    if (cyc_cnt == 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    clk_i = 0;
    rst_i = 1;
    cyc_i = 0;
    stb_i = 0;
    we_i = 0;
    adr_i = 0;
    sel_i = 0;
    dat_i = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_bringup;
    t_div;
    t_lookup;
    t_baud;
    print_verdict;
  end
endmodule // tb_top

/* File: dv/ufb_checker.sv */
// port assertions for the fractional baud block
`timescale 1ns/1ns
`include "ufb_map.vh"
module ufb_checker (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:2] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // controls and ticks
  input wire tx_en_o,
  input wire rx_en_o,
  input wire tx_fifo_en_o,
  input wire rx_fifo_en_o,
  input wire tx_tick_o,
  input wire rx_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr_gate = ack_o && we_i && sel_i[0] && adr_i == `UFB_IDX_GATE;
  wire wr_fifo = ack_o && we_i && sel_i[0] && adr_i == `UFB_IDX_FIFO_GATE;
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; ack_o |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_dat; !ack_o |-> dat_o == 32'h0000_0000; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_tx; wr_gate |=> tx_en_o == $past(dat_i[0]); endproperty
  a_tx: assert property (p_tx) else $error("tx enable wrong");
  property p_rx; wr_gate |=> rx_en_o == $past(dat_i[1]); endproperty
  a_rx: assert property (p_rx) else $error("rx enable wrong");
  property p_txh; $changed(tx_en_o) |-> $past(wr_gate); endproperty
  a_txh: assert property (p_txh) else $error("tx enable moved alone");
  property p_rxh; $changed(rx_en_o) |-> $past(wr_gate); endproperty
  a_rxh: assert property (p_rxh) else $error("rx enable moved alone");
  // fifo gate outputs sit one register behind the stored bits
  property p_fifo;
    $changed({tx_fifo_en_o, rx_fifo_en_o}) |-> $past(wr_fifo);
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo gate moved alone");
  property p_txoff; !tx_en_o [*3] |-> !tx_tick_o; endproperty
  a_txoff: assert property (p_txoff) else $error("tx tick while off");
  property p_rxoff; !rx_en_o [*3] |-> !rx_tick_o; endproperty
  a_rxoff: assert property (p_rxoff) else $error("rx tick while off");
endmodule // ufb_checker
bind ufb_top ufb_checker u_chk (.*);

/* File: dv/ufb_peer.sv */
// serial peer: times the bit period it is clocked with
`timescale 1ns/1ns
module ufb_peer (
  input wire clk_i,
  input wire tick_i,
  output reg [19:0] gap_o
);
  reg [19:0] cnt_reg;
  initial cnt_reg = 20'h0_0001;
  initial gap_o = 20'h0_0000;
  // the peer's bit timer restarts on every tick
  always @(posedge clk_i) begin
    cnt_reg <= tick_i ? 20'h0_0001 : cnt_reg + 20'h0_0001;
    if (tick_i) begin
      gap_o <= cnt_reg;
    end
  end
endmodule // ufb_peer

/* File: inc/ufb_map.vh */
// register indexes, field positions, reset values and timing counts of the baud block
`ifndef UFB_MAP_VH
`define UFB_MAP_VH

// register indexes; byte address is four times the index
`define UFB_IDX_GATE 6'h03
`define UFB_IDX_DIV_LO 6'h04
`define UFB_IDX_DIV_MID 6'h05
`define UFB_IDX_DIV_HI 6'h06
`define UFB_IDX_TXM_LO 6'h07
`define UFB_IDX_TXM_HI 6'h08
`define UFB_IDX_RXM_LO 6'h09
`define UFB_IDX_RXM_HI 6'h0A
`define UFB_IDX_LOOKUP 6'h20
`define UFB_IDX_STATUS 6'h21
`define UFB_IDX_FIFO_GATE 6'h30

// field positions
`define UFB_BIT_TX 0
`define UFB_BIT_RX 1
`define UFB_BIT_APPLY 8
`define UFB_DIV_HI_W 3

// reset values
`define UFB_RST_GATE 2'h0
`define UFB_RST_DIV 19'h0_0000
`define UFB_RST_MASK 16'h0000
`define UFB_RST_IDX 5'h00

// cycles from a lookup write to the masks being loaded
`define UFB_APPLY_CYCLES 2'h2

`endif

/* File: rtl/ufb_baud_gen.v */
// one direction of the fractional baud generator: divisor plus 16-step stretch mask
`timescale 1ns/1ns
`include "ufb_map.vh"
module ufb_baud_gen (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // settings
  input wire run_i,
  input wire [18:0] div_i,
  input wire [15:0] mask_i,
  // output
  output reg tick_o
);

  reg [19:0] cnt_reg;
  reg [3:0] step_reg;
  wire [19:0] limit;

  // a set mask bit makes this bit period one internal clock longer
  assign limit = {1'b0, div_i} + {19'h0_0000, mask_i[step_reg]};

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 20'h0_0000;
      step_reg <= 4'h0;
      tick_o <= 1'b0;
    end else if (!run_i || div_i == `UFB_RST_DIV) begin
      // a zero divisor is meaningless, so the generator stays parked
      cnt_reg <= 20'h0_0000;
      step_reg <= 4'h0;
      tick_o <= 1'b0;
    end else if (cnt_reg >= limit - 20'h0_0001) begin
      cnt_reg <= 20'h0_0000;
      step_reg <= step_reg + 4'h1;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 20'h0_0001;
      tick_o <= 1'b0;
    end
  end

endmodule // ufb_baud_gen

/* File: rtl/ufb_mask_rom.v */
// fraction mask lookup table with registered read data
`timescale 1ns/1ns
module ufb_mask_rom (
  // clock
  input wire clk_i,
  // lookup
  input wire [4:0] idx_i,
  output reg [15:0] tx_mask_o,
  output reg [15:0] rx_even_o,
  output reg [15:0] rx_odd_o
);

  reg [47:0] row;

  always @* begin
    case (idx_i)
      5'd0: row = {16'h0000, 16'h0000, 16'h0000};
      5'd1: row = {16'h0000, 16'h0000, 16'h0000};
      5'd2: row = {16'h0100, 16'h0000, 16'h0100};
      5'd3: row = {16'h0020, 16'h0400, 16'h0020};
      5'd4: row = {16'h0010, 16'h0100, 16'h0010};
      5'd5: row = {16'h0208, 16'h0040, 16'h0208};
      5'd6: row = {16'h0104, 16'h0820, 16'h0108};
      5'd7: row = {16'h0844, 16'h0210, 16'h0884};
      5'd8: row = {16'h0444, 16'h0110, 16'h0444};
      5'd9: row = {16'h0122, 16'h0888, 16'h0224};
      5'd10: row = {16'h0912, 16'h0448, 16'h0924};
      5'd11: row = {16'h0492, 16'h0248, 16'h0492};
      5'd12: row = {16'h0252, 16'h0928, 16'h0292};
      5'd13: row = {16'h094A, 16'h04A4, 16'h0A52};
      5'd14: row = {16'h052A, 16'h0AA4, 16'h054A};
      5'd15: row = {16'h0AAA, 16'h0954, 16'h04AA};
      5'd16: row = {16'h0AAA, 16'h0554, 16'h0AAA};
      5'd17: row = {16'h0555, 16'h0AD4, 16'h05AA};
      5'd18: row = {16'h0B55, 16'h0AB4, 16'h055A};
      5'd19: row = {16'h06B5, 16'h05AC, 16'h0B56};
      5'd20: row = {16'h05B5, 16'h0D6C, 16'h06D6};
      5'd21: row = {16'h0B6D, 16'h0B6A, 16'h0DB6};
      5'd22: row = {16'h076D, 16'h06DA, 16'h0BB6};
      5'd23: row = {16'h0EDD, 16'h0DDA, 16'h076E};
      5'd24: row = {16'h0DDD, 16'h0BBA, 16'h0EEE};
      5'd25: row = {16'h07BB, 16'h0F7A, 16'h0DDE};
      5'd26: row = {16'h0F7B, 16'h0EF6, 16'h07DE};
      5'd27: row = {16'h0DF7, 16'h0BF6, 16'h0F7E};
      5'd28: row = {16'h07F7, 16'h0FEE, 16'h0EFE};
      5'd29: row = {16'h0FDF, 16'h0FBE, 16'h07FE};
      5'd30: row = {16'h0F7F, 16'h0EFE, 16'h0FFE};
      default: row = {16'h0FFF, 16'h0FFE, 16'h0FFD};
    endcase
  end

  always @(posedge clk_i) begin
    tx_mask_o <= row[47:32];
    rx_even_o <= row[31:16];
    rx_odd_o <= row[15:0];
  end

endmodule // ufb_mask_rom

/* File: rtl/ufb_top.v */
// channel enable, fifo gate and fractional baud generator behind a wishbone slave
//
// What this block does
// - bit 0 of the channel enable register switches the transmitter on and off.
// - bit 1 of the channel enable register switches the receiver on and off.
// - each direction's bit timing comes from a 19-bit integer divisor and its own 16-bit stretch mask.
// - the divisor is split over low, middle and upper byte registers, with the upper five bits reserved as zero.
// - the mask table holds 32 entries, zero at index 0 and 1 and transmit mask 0x0FFF at 31.
// - the fifo gate register enables the transmit fifo with bit 0 and the receive fifo with bit 1.
`timescale 1ns/1ns
`include "ufb_map.vh"
module ufb_top (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:2] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // channel controls
  output reg tx_en_o,
  output reg rx_en_o,
  output reg tx_fifo_en_o,
  output reg rx_fifo_en_o,
  // baud ticks
  output wire tx_tick_o,
  output wire rx_tick_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [1:0] gate_reg;
  reg [1:0] fifo_gate_reg;
  reg [18:0] div_reg;
  reg [15:0] txm_reg;
  reg [15:0] rxm_reg;
  reg [4:0] idx_reg;
  reg [1:0] apply_reg;
  reg [31:0] rdata_next;
  wire req;
  wire wr;
  wire [15:0] rom_tx;
  wire [15:0] rom_rx_even;
  wire [15:0] rom_rx_odd;
  wire [15:0] rom_rx;

  // classic single cycle: one wait state, ack drops the cycle after it rose
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i & sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // mask table and column choice

  ufb_mask_rom u_rom (
    .clk_i(clk_i),
    .idx_i(idx_reg),
    .tx_mask_o(rom_tx),
    .rx_even_o(rom_rx_even),
    .rx_odd_o(rom_rx_odd)
  );

  // the divisor's lowest bit picks the receive column
  assign rom_rx = div_reg[0] ? rom_rx_odd : rom_rx_even;

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_reg <= `UFB_RST_GATE;
      fifo_gate_reg <= `UFB_RST_GATE;
      div_reg <= `UFB_RST_DIV;
      txm_reg <= `UFB_RST_MASK;
      rxm_reg <= `UFB_RST_MASK;
      idx_reg <= `UFB_RST_IDX;
      apply_reg <= 2'h0;
    end else begin
      if (apply_reg != 2'h0) begin
        apply_reg <= apply_reg - 2'h1;
      end
      // table read data is registered, so masks load once it has settled
      if (apply_reg == 2'h1) begin
        txm_reg <= rom_tx;
        rxm_reg <= rom_rx;
      end
      if (wr) begin
        if (adr_i == `UFB_IDX_GATE) begin
          // only the two enable bits are stored; upper bits read as zero
          gate_reg <= dat_i[1:0];
        end else if (adr_i == `UFB_IDX_FIFO_GATE) begin
          fifo_gate_reg <= dat_i[1:0];
        end else if (adr_i == `UFB_IDX_DIV_LO) begin
          div_reg[7:0] <= dat_i[7:0];
        end else if (adr_i == `UFB_IDX_DIV_MID) begin
          div_reg[15:8] <= dat_i[7:0];
        end else if (adr_i == `UFB_IDX_DIV_HI) begin
          div_reg[18:16] <= dat_i[2:0];
        end else if (adr_i == `UFB_IDX_TXM_LO) begin
          txm_reg[7:0] <= dat_i[7:0];
        end else if (adr_i == `UFB_IDX_TXM_HI) begin
          txm_reg[15:8] <= dat_i[7:0];
        end else if (adr_i == `UFB_IDX_RXM_LO) begin
          rxm_reg[7:0] <= dat_i[7:0];
        end else if (adr_i == `UFB_IDX_RXM_HI) begin
          rxm_reg[15:8] <= dat_i[7:0];
        end else if (adr_i == `UFB_IDX_LOOKUP) begin
          idx_reg <= dat_i[4:0];
          if (sel_i[1] && dat_i[`UFB_BIT_APPLY]) begin
            apply_reg <= `UFB_APPLY_CYCLES;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads; unmapped indexes answer with zero

  always @* begin
    rdata_next = 32'h0000_0000;
    if (adr_i == `UFB_IDX_GATE) begin
      rdata_next[1:0] = gate_reg;
    end else if (adr_i == `UFB_IDX_FIFO_GATE) begin
      rdata_next[1:0] = fifo_gate_reg;
    end else if (adr_i == `UFB_IDX_DIV_LO) begin
      rdata_next[7:0] = div_reg[7:0];
    end else if (adr_i == `UFB_IDX_DIV_MID) begin
      rdata_next[7:0] = div_reg[15:8];
    end else if (adr_i == `UFB_IDX_DIV_HI) begin
      rdata_next[2:0] = div_reg[18:16];
    end else if (adr_i == `UFB_IDX_TXM_LO) begin
      rdata_next[7:0] = txm_reg[7:0];
    end else if (adr_i == `UFB_IDX_TXM_HI) begin
      rdata_next[7:0] = txm_reg[15:8];
    end else if (adr_i == `UFB_IDX_RXM_LO) begin
      rdata_next[7:0] = rxm_reg[7:0];
    end else if (adr_i == `UFB_IDX_RXM_HI) begin
      rdata_next[7:0] = rxm_reg[15:8];
    end else if (adr_i == `UFB_IDX_LOOKUP) begin
      rdata_next = {rom_rx, rom_tx};
    end else if (adr_i == `UFB_IDX_STATUS) begin
      rdata_next[4:0] = {apply_reg != 2'h0, fifo_gate_reg, gate_reg};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= req ? rdata_next : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel controls

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_en_o <= 1'b0;
      rx_en_o <= 1'b0;
      tx_fifo_en_o <= 1'b0;
      rx_fifo_en_o <= 1'b0;
    end else begin
      tx_en_o <= gate_reg[`UFB_BIT_TX];
      rx_en_o <= gate_reg[`UFB_BIT_RX];
      tx_fifo_en_o <= fifo_gate_reg[`UFB_BIT_TX];
      rx_fifo_en_o <= fifo_gate_reg[`UFB_BIT_RX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generators; each direction runs only while its side is enabled

  ufb_baud_gen u_tx_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(gate_reg[`UFB_BIT_TX]),
    .div_i(div_reg),
    .mask_i(txm_reg),
    .tick_o(tx_tick_o)
  );

  ufb_baud_gen u_rx_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(gate_reg[`UFB_BIT_RX]),
    .div_i(div_reg),
    .mask_i(rxm_reg),
    .tick_o(rx_tick_o)
  );

endmodule // ufb_top
